// file: verilog/timer_arb_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the timer
// Assumes: 32-bit Avalon-MM word registers at byte addresses
// Notes:   definitions only
`ifndef TIMER_ARB_DEFS_SVH
`define TIMER_ARB_DEFS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL        6'h00
`define OFS_COUNT       6'h04
`define OFS_GENERAL     6'h08
`define OFS_CYCLE       6'h0c
`define OFS_DUTY_BUF    6'h10
`define OFS_DUTY        6'h14
`define OFS_DOWN_VALUE  6'h18
`define OFS_DOWN_START  6'h1c
`define OFS_FLAGS       6'h20
`define OFS_MASK        6'h24
`define OFS_LINK        6'h28

// ----------------------------------------------------------------------
// control bits
// ----------------------------------------------------------------------
`define CTRL_RUN        0
`define CTRL_CLR_MATCH  1
`define CTRL_CLR_WRAP   2
`define CTRL_CAPTURE    3
`define CTRL_W          4

// ----------------------------------------------------------------------
// flag bits (status and mask share this layout)
// ----------------------------------------------------------------------
`define FLG_MATCH       0
`define FLG_CAPTURE     1
`define FLG_OVERFLOW    2
`define FLG_UNDERFLOW   3
`define FLG_CYCLE       4
`define FLG_W           5

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define CNT_W           16
`define CTRL_RST        4'h0
`define CNT_RST         16'h0000
`define CNT_ZERO        16'h0000
`define CNT_TOP         16'hffff
`define FLAGS_RST       5'h00
`define PRESCALE_DEF    8

`endif

// file: verilog/timer_arb_pkg.sv
// Purpose: types shared by the timer contention logic
// Assumes: nothing
// Notes:   bus access phases
`default_nettype none
package timer_arb_pkg;
    typedef enum logic [0:0] {
        ACC_FIRST  = 1'b0,
        ACC_SECOND = 1'b1
    } access_state_t;
endpackage : timer_arb_pkg
`default_nettype wire

// file: verilog/timer_access_contention_arbiter.sv
// Purpose: one timer channel set with the priority logic for bus-write / event contention
// Assumes: Avalon-MM slave, every access lasts two states, the second is ACC_SECOND
// Notes:   flags are write-one-to-clear; dma clear inputs come from logic on clk
// Overview of operation
// - counter write in second state beats compare-match clear
// - that compare-match still sets its flag and toggles the waveform output
// - capture colliding with general register write keeps cpu value, flag still set
// - counter write colliding with increment loads value, no increment
// - overflow during counter write keeps written value, overflow flag still set
// - event during flag clear write sets flag; set wins
// - cycle-match buffer transfer colliding with duty write loads the OR
// - dma clear of capture or cycle flag wins over its setting event
// - dma clear request lasts two or more states; clearing spans all of it
// - down-count start bit ignores writes of zero
// - zero written to running down counter stops it at next underflow
// - start at zero gives no pulse but sets underflow flag
// - capture pin copies counter and sets flag even when counter stopped
// - underflow during down counter write keeps zero, discards write
// - underflow during start-bit write leaves start bit zero
//
// The address map and the Avalon-MM register port are this design's own decisions.
`default_nettype none
`include "timer_arb_defs.svh"

module timer_access_contention_arbiter
    import timer_arb_pkg::*;
#(
    parameter int PRESCALE = `PRESCALE_DEF
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic [5:0]          address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [31:0]         writedata,
    output logic      [31:0]         readdata,
    output logic                     waitrequest,
    input  wire logic                capture_pin,
    input  wire logic                dma_clr_capture,
    input  wire logic                dma_clr_cycle,
    output logic                     wave_out,
    output logic                     pwm_out,
    output logic                     one_shot_out,
    output logic                     irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    access_state_t          acc_q;
    logic [31:0]            rdata_q;
    logic [3:0]             ctrl_q;
    logic [`CNT_W-1:0]      free_running_count_q;
    logic [`CNT_W-1:0]      general_match_capture_reg_q;
    logic [`CNT_W-1:0]      cycle_period_reg_q;
    logic [`CNT_W-1:0]      duty_buffer_reg_q;
    logic [`CNT_W-1:0]      duty_reg_q;
    logic [`CNT_W-1:0]      down_count_value_q;
    logic                   down_count_start_reg_q;
    logic [`FLG_W-1:0]      timer_flag_reg_q;
    logic [`FLG_W-1:0]      mask_q;
    logic                   timer_link_reg_q;
    logic                   wave_q;
    logic                   pwm_q;
    logic [7:0]             div_q;
    logic [2:0]             pin_q;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire        req       = read | write;
    wire        second    = (acc_q == ACC_SECOND);
    wire        wr2       = write & second;
    wire        wr_ctrl   = wr2 & (address == `OFS_CTRL);
    wire        wr_cnt    = wr2 & (address == `OFS_COUNT);
    wire        wr_gen    = wr2 & (address == `OFS_GENERAL);
    wire        wr_cyc    = wr2 & (address == `OFS_CYCLE);
    wire        wr_buf    = wr2 & (address == `OFS_DUTY_BUF);
    wire        wr_duty   = wr2 & (address == `OFS_DUTY);
    wire        wr_down   = wr2 & (address == `OFS_DOWN_VALUE);
    wire        wr_start  = wr2 & (address == `OFS_DOWN_START);
    wire        wr_flags  = wr2 & (address == `OFS_FLAGS);
    wire        wr_mask   = wr2 & (address == `OFS_MASK);
    wire        wr_link   = wr2 & (address == `OFS_LINK);
    wire [`CNT_W-1:0] wval = writedata[`CNT_W-1:0];

    assign waitrequest = req & ~second;
    assign readdata    = rdata_q;

    // ------------------------------------------------------------------
    // timer events
    // ------------------------------------------------------------------
    wire        tick      = (div_q == 8'(PRESCALE - 1));
    wire        running   = ctrl_q[`CTRL_RUN];
    wire        cap_mode  = ctrl_q[`CTRL_CAPTURE];
    wire        inc       = running & tick;
    wire        match_ev  = inc & ~cap_mode & (free_running_count_q == general_match_capture_reg_q);
    wire        wrap_ev   = inc & (free_running_count_q == `CNT_TOP);
    wire        cyc_ev    = inc & (free_running_count_q == cycle_period_reg_q);
    wire        cap_ev    = cap_mode & pin_q[1] & ~pin_q[2];
    wire        down_run  = down_count_start_reg_q;
    wire        unf_ev    = down_run & tick & (down_count_value_q == `CNT_ZERO);
    wire        link_go   = match_ev & timer_link_reg_q;

    // counter next value: a cpu write beats clear, overflow and increment
    wire [`CNT_W-1:0] cnt_d =
        wr_cnt                               ? wval :
        (match_ev & ctrl_q[`CTRL_CLR_MATCH]) ? `CNT_ZERO :
        (wrap_ev & ctrl_q[`CTRL_CLR_WRAP])   ? `CNT_ZERO :
        inc                                  ? free_running_count_q + 16'h0001 :
                                               free_running_count_q;

    // capture copies the counter whether or not it runs, unless the cpu writes
    wire [`CNT_W-1:0] gen_d =
        wr_gen ? wval :
        cap_ev ? free_running_count_q :
                 general_match_capture_reg_q;

    // buffer transfer merged with a colliding duty write
    wire [`CNT_W-1:0] duty_d =
        (cyc_ev & wr_duty) ? (duty_buffer_reg_q | wval) :
        cyc_ev             ? duty_buffer_reg_q :
        wr_duty            ? wval :
                             duty_reg_q;

    // underflow holds zero and drops any colliding write
    wire [`CNT_W-1:0] down_d =
        unf_ev                      ? `CNT_ZERO :
        wr_down                     ? wval :
        (down_run & tick)           ? down_count_value_q - 16'h0001 :
                                      down_count_value_q;

    // start bit: only ones are taken, underflow clear wins
    wire        start_set = (wr_start & writedata[0]) | link_go;
    wire        start_d   = unf_ev ? 1'b0 :
                            start_set ? 1'b1 : down_count_start_reg_q;

    wire [`FLG_W-1:0] flag_set;
    assign flag_set[`FLG_MATCH]     = match_ev;
    assign flag_set[`FLG_CAPTURE]   = cap_ev;
    assign flag_set[`FLG_OVERFLOW]  = wrap_ev;
    assign flag_set[`FLG_UNDERFLOW] = unf_ev;
    assign flag_set[`FLG_CYCLE]     = cyc_ev;

    wire [`FLG_W-1:0] cpu_clr = wr_flags ? writedata[`FLG_W-1:0] : `FLAGS_RST;
    wire [`FLG_W-1:0] dma_clr = {dma_clr_cycle, 2'b00, dma_clr_capture, 1'b0};

    // hardware set beats cpu clear; dma clear beats hardware set
    wire [`FLG_W-1:0] flags_d =
        ((timer_flag_reg_q & ~cpu_clr) | flag_set) & ~dma_clr;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        unique case (address)
            `OFS_CTRL:       rmux[3:0]        = ctrl_q;
            `OFS_COUNT:      rmux[15:0]       = free_running_count_q;
            `OFS_GENERAL:    rmux[15:0]       = general_match_capture_reg_q;
            `OFS_CYCLE:      rmux[15:0]       = cycle_period_reg_q;
            `OFS_DUTY_BUF:   rmux[15:0]       = duty_buffer_reg_q;
            `OFS_DUTY:       rmux[15:0]       = duty_reg_q;
            `OFS_DOWN_VALUE: rmux[15:0]       = down_count_value_q;
            `OFS_DOWN_START: rmux[0]          = down_count_start_reg_q;
            `OFS_FLAGS:      rmux[`FLG_W-1:0] = timer_flag_reg_q;
            `OFS_MASK:       rmux[`FLG_W-1:0] = mask_q;
            `OFS_LINK:       rmux[0]          = timer_link_reg_q;
            default:         rmux             = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // bus sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q   <= ACC_FIRST;
            rdata_q <= 32'h0000_0000;
        end else begin
            acc_q <= (req & ~second) ? ACC_SECOND : ACC_FIRST;
            if (read & ~second) begin
                rdata_q <= rmux;
            end
        end
    end

    // ------------------------------------------------------------------
    // prescaler and capture pin synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= 8'h00;
            pin_q <= 3'h0;
        end else begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
            pin_q <= {pin_q[1:0], capture_pin};
        end
    end

    // ------------------------------------------------------------------
    // timer registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q                      <= `CTRL_RST;
            free_running_count_q        <= `CNT_RST;
            general_match_capture_reg_q <= `CNT_RST;
            cycle_period_reg_q          <= `CNT_RST;
            duty_buffer_reg_q           <= `CNT_RST;
            duty_reg_q                  <= `CNT_RST;
            down_count_value_q          <= `CNT_RST;
            down_count_start_reg_q      <= 1'b0;
            timer_flag_reg_q            <= `FLAGS_RST;
            mask_q                      <= `FLAGS_RST;
            timer_link_reg_q            <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_q <= writedata[3:0];
            if (wr_cyc)  cycle_period_reg_q <= wval;
            if (wr_buf)  duty_buffer_reg_q  <= wval;
            if (wr_mask) mask_q <= writedata[`FLG_W-1:0];
            if (wr_link) timer_link_reg_q <= writedata[0];
            free_running_count_q        <= cnt_d;
            general_match_capture_reg_q <= gen_d;
            duty_reg_q                  <= duty_d;
            down_count_value_q          <= down_d;
            down_count_start_reg_q      <= start_d;
            timer_flag_reg_q            <= flags_d;
        end
    end

    // ------------------------------------------------------------------
    // waveform outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wave_q <= 1'b0;
            pwm_q  <= 1'b0;
        end else begin
            if (match_ev) wave_q <= ~wave_q;
            if (cyc_ev) begin
                pwm_q <= 1'b1;
            end else if (inc & (free_running_count_q == duty_reg_q)) begin
                pwm_q <= 1'b0;
            end
        end
    end

    assign wave_out     = wave_q;
    assign pwm_out      = pwm_q;
    // no pulse while the down counter holds zero
    assign one_shot_out = down_count_start_reg_q & (down_count_value_q != `CNT_ZERO);
    assign irq          = |(timer_flag_reg_q & mask_q);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_WRITE_BEATS_CLEAR: assert property (
        wr_cnt & match_ev & ctrl_q[`CTRL_CLR_MATCH] |=> free_running_count_q == $past(wval))
        else $error("counter write lost to match clear");
    AST_MATCH_STILL_VALID: assert property (
        match_ev & ~dma_clr_capture |=> timer_flag_reg_q[`FLG_MATCH] && wave_q != $past(wave_q))
        else $error("match did not set flag or toggle output");
    AST_CAPTURE_KEEPS_CPU: assert property (
        wr_gen & cap_ev & ~dma_clr_capture
        |=> general_match_capture_reg_q == $past(wval) && timer_flag_reg_q[`FLG_CAPTURE])
        else $error("capture overwrote cpu value or lost flag");
    AST_WRITE_NO_INC: assert property (
        wr_cnt & inc |=> free_running_count_q == $past(wval))
        else $error("counter incremented over a write");
    AST_WRAP_WRITE: assert property (
        wr_cnt & wrap_ev |=> free_running_count_q == $past(wval)
            && timer_flag_reg_q[`FLG_OVERFLOW])
        else $error("overflow collision mishandled");
    AST_SET_WINS: assert property (
        wr_flags & writedata[`FLG_OVERFLOW] & wrap_ev |=> timer_flag_reg_q[`FLG_OVERFLOW])
        else $error("flag clear beat flag set");
    AST_DUTY_OR: assert property (
        cyc_ev & wr_duty |=> duty_reg_q == ($past(duty_buffer_reg_q) | $past(wval)))
        else $error("duty collision not merged");
    AST_DMA_CLEAR_WINS: assert property (
        dma_clr_cycle |=> !timer_flag_reg_q[`FLG_CYCLE])
        else $error("dma clear lost to cycle match");
    AST_ZERO_WRITE_IGNORED: assert property (
        wr_start & ~writedata[0] & down_count_start_reg_q & ~unf_ev |=> down_count_start_reg_q)
        else $error("start bit cleared by zero write");
    AST_UNDERFLOW_HALT: assert property (
        unf_ev & ~dma_clr_capture
        |=> !down_count_start_reg_q && down_count_value_q == `CNT_ZERO
            && timer_flag_reg_q[`FLG_UNDERFLOW])
        else $error("underflow did not halt down counter");
    AST_NO_PULSE_AT_ZERO: assert property (
        start_set & ~down_run & (down_count_value_q == `CNT_ZERO)
        |=> !one_shot_out ##[0:8] timer_flag_reg_q[`FLG_UNDERFLOW])
        else $error("start at zero gave a pulse or no underflow flag");
    AST_CAPTURE_STOPPED: assert property (
        cap_ev & ~wr_gen & ~running |=> general_match_capture_reg_q == $past(free_running_count_q))
        else $error("capture failed while stopped");
    AST_UNF_KEEPS_ZERO: assert property (
        unf_ev & wr_down |=> down_count_value_q == `CNT_ZERO)
        else $error("down write beat underflow");
    AST_UNF_BEATS_START: assert property (
        unf_ev & wr_start & writedata[0] |=> !down_count_start_reg_q)
        else $error("start bit set during underflow");
    AST_ACCESS_TWO_STATES: assert property (
        req & ~second |=> !waitrequest)
        else $error("access took more than two states");

    COV_MATCH_WRITE: cover property (wr_cnt & match_ev);
    COV_DUTY_MERGE:  cover property (cyc_ev & wr_duty);
    COV_UNF_START:   cover property (unf_ev & wr_start);
    COV_DMA_CLEAR:   cover property (dma_clr_capture & cap_ev);

endmodule : timer_access_contention_arbiter
`default_nettype wire

// file: sim/dma_clear_model.sv
// Purpose: dma controller side that raises flag-clear requests
// Assumes: same clock as the timer; requests start the edge after go
// Notes:   a request never lasts fewer than two states
`default_nettype none
module dma_clear_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       go,
    input  wire logic       sel,
    input  wire logic [3:0] len,
    output logic            clr_capture,
    output logic            clr_cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] left_q;
    logic       sel_q;
    // ----------------------------------------------------------------------
    // request length counter
    // ----------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            left_q <= 4'h0;
            sel_q  <= 1'b0;
        end else if (go) begin
            left_q <= (len < 4'h2) ? 4'h2 : len;
            sel_q  <= sel;
        end else if (left_q != 4'h0) begin
            left_q <= left_q - 4'h1;
        end
    end
    assign clr_capture = (left_q != 4'h0) && !sel_q;
    assign clr_cycle   = (left_q != 4'h0) && sel_q;
endmodule : dma_clear_model
`default_nettype wire

// file: sim/timer_access_contention_arbiter_tb.sv
// Purpose: self-checking bench of the timer contention logic
// Assumes: PRESCALE 1, so every clock is a timer tick
// Notes:   reads queue their expected word; a monitor compares
`default_nettype none
`include "timer_arb_defs.svh"
module timer_access_contention_arbiter_tb;
    import timer_arb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_b, read, write, capture_pin, go, sel;
    logic [5:0]  address;
    logic [31:0] writedata, readdata, rnd, v;
    logic [3:0]  len;
    logic        waitrequest, dma_cap, dma_cyc, wave_out, pwm_out, one_shot_out, irq;
    logic [31:0] expq[$];
    logic [5:0]  rst_addr[5] = '{`OFS_CTRL, `OFS_COUNT, `OFS_FLAGS, `OFS_DOWN_START, 6'h3c};
    int          fail_count, checked;
    timer_access_contention_arbiter #(.PRESCALE(1)) uut (
        .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .capture_pin(capture_pin), .dma_clr_capture(dma_cap), .dma_clr_cycle(dma_cyc),
        .wave_out(wave_out), .pwm_out(pwm_out), .one_shot_out(one_shot_out), .irq(irq));
    dma_clear_model dma (
        .clk(clk), .rst_b(rst_b), .go(go), .sel(sel), .len(len),
        .clr_capture(dma_cap), .clr_cycle(dma_cyc));
    // ----------------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic fail(input string m);
        fail_count++;
        $display("FAIL %0t %s", $time, m);
    endtask : fail
    task automatic check_read(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
    endtask : check_read
    task automatic check_pin(input logic got, input logic exp);
        checked++;
        if (got !== exp) fail("output level wrong");
    endtask : check_pin
    // one access; caller stands just after a rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        address   <= a;
        read      <= !wr;
        write     <= wr;
        writedata <= d;
        if (!wr) expq.push_back(d);
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
    endtask : bus
    task automatic idle(input int n);
        read  <= 1'b0;
        write <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic pin_pulse();
        capture_pin <= 1'b1;
        idle(3);
        capture_pin <= 1'b0;
        idle(8);
    endtask : pin_pulse
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // ----------------------------------------------------------------------
    // clock, monitor, watchdog
    // ----------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (read && waitrequest === 1'b0) begin
            v = (expq.size() > 0) ? expq.pop_front() : 32'hdead_beef;
            check_read(readdata, v);
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail("watchdog expired");
        summarize();
    end
    // ----------------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------------
    initial begin
        {rst_b, read, write, capture_pin, go, sel} = 6'h00;
        address = 6'h00;
        writedata = 32'h0000_0000;
        len = 4'h0;
        rnd = 32'h26aa;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        foreach (rst_addr[i])
            bus(1'b0, rst_addr[i], 32'h0000_0000);
        idle(1);
        check_pin(irq, 1'b0);
        $display("test reset done");
        rnd = lfsr(lfsr(rnd));
        bus(1'b1, `OFS_CTRL, 32'h0000_0008);
        bus(1'b1, `OFS_COUNT, {16'h0000, rnd[15:0]});
        pin_pulse();
        bus(1'b0, `OFS_GENERAL, {16'h0000, rnd[15:0]});
        bus(1'b0, `OFS_FLAGS, 32'h0000_0002);
        bus(1'b1, `OFS_MASK, 32'h0000_0002);
        idle(1);
        check_pin(irq, 1'b1);
        bus(1'b1, `OFS_MASK, 32'h0000_0000);
        idle(1);
        check_pin(irq, 1'b0);
        bus(1'b1, `OFS_MASK, 32'h0000_0002);
        bus(1'b1, `OFS_FLAGS, 32'h0000_0002);
        idle(1);
        check_pin(irq, 1'b0);
        $display("test capture and interrupt done");
        go  <= 1'b1;
        len <= 4'h8;
        capture_pin <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        pin_pulse();
        bus(1'b0, `OFS_FLAGS, 32'h0000_0000);
        pin_pulse();
        go  <= 1'b1;
        len <= 4'h2;
        @(posedge clk);
        go <= 1'b0;
        idle(4);
        bus(1'b0, `OFS_FLAGS, 32'h0000_0000);
        go  <= 1'b1;
        sel <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        idle(4);
        $display("test dma clear done");
        bus(1'b1, `OFS_GENERAL, 32'h0000_0100);
        bus(1'b1, `OFS_CYCLE, 32'h0000_0200);
        bus(1'b1, `OFS_CTRL, 32'h0000_0005);
        bus(1'b1, `OFS_COUNT, 32'h0000_fffe);
        bus(1'b1, `OFS_COUNT, 32'h0000_5555);
        bus(1'b0, `OFS_COUNT, 32'h0000_5555);
        bus(1'b1, `OFS_CTRL, 32'h0000_0000);
        bus(1'b0, `OFS_FLAGS, 32'h0000_0004);
        bus(1'b1, `OFS_FLAGS, 32'h0000_001f);
        $display("test counter write done");
        bus(1'b1, `OFS_DOWN_VALUE, 32'h0000_0000);
        bus(1'b1, `OFS_DOWN_START, 32'h0000_0001);
        idle(1);
        check_pin(one_shot_out, 1'b0);
        idle(4);
        bus(1'b0, `OFS_FLAGS, 32'h0000_0008);
        bus(1'b0, `OFS_DOWN_START, 32'h0000_0000);
        bus(1'b1, `OFS_FLAGS, 32'h0000_001f);
        bus(1'b1, `OFS_DOWN_VALUE, 32'h0000_0040);
        bus(1'b1, `OFS_DOWN_START, 32'h0000_0001);
        idle(1);
        check_pin(one_shot_out, 1'b1);
        bus(1'b1, `OFS_DOWN_START, 32'h0000_0000);
        bus(1'b0, `OFS_DOWN_START, 32'h0000_0001);
        bus(1'b1, `OFS_DOWN_VALUE, 32'h0000_0000);
        bus(1'b0, `OFS_DOWN_START, 32'h0000_0001);
        idle(4);
        bus(1'b0, `OFS_DOWN_START, 32'h0000_0000);
        bus(1'b0, `OFS_FLAGS, 32'h0000_0008);
        idle(2);
        $display("test down counter done");
        rnd = lfsr(rnd);
        bus(1'b1, `OFS_FLAGS, 32'h0000_001f);
        bus(1'b1, `OFS_CTRL, 32'h0000_0003);
        bus(1'b1, `OFS_COUNT, 32'h0000_00ff);
        bus(1'b1, `OFS_COUNT, {16'h0000, rnd[15:0]});
        bus(1'b0, `OFS_COUNT, {16'h0000, rnd[15:0]});
        bus(1'b0, `OFS_FLAGS, 32'h0000_0001);
        idle(1);
        check_pin(wave_out, 1'b1);
        bus(1'b1, `OFS_COUNT, 32'h0000_00ff);
        bus(1'b1, `OFS_FLAGS, 32'h0000_0001);
        bus(1'b0, `OFS_FLAGS, 32'h0000_0001);
        idle(1);
        check_pin(wave_out, 1'b0);
        bus(1'b1, `OFS_DUTY_BUF, 32'h0000_aaaa);
        // duty write below collides with the cycle match on purpose
        bus(1'b1, `OFS_COUNT, 32'h0000_01ff);
        bus(1'b1, `OFS_DUTY, 32'h0000_5555);
        bus(1'b0, `OFS_DUTY, 32'h0000_ffff);
        idle(1);
        check_pin(pwm_out, 1'b1);
        bus(1'b1, `OFS_CTRL, 32'h0000_0000);
        bus(1'b1, `OFS_DOWN_VALUE, 32'h0000_0001);
        bus(1'b1, `OFS_DOWN_START, 32'h0000_0001);
        bus(1'b1, `OFS_DOWN_VALUE, 32'h0000_5555);
        bus(1'b0, `OFS_DOWN_VALUE, 32'h0000_0000);
        bus(1'b1, `OFS_DOWN_VALUE, 32'h0000_0001);
        bus(1'b1, `OFS_DOWN_START, 32'h0000_0001);
        bus(1'b1, `OFS_DOWN_START, 32'h0000_0001);
        bus(1'b0, `OFS_DOWN_START, 32'h0000_0000);
        bus(1'b1, `OFS_FLAGS, 32'h0000_001f);
        bus(1'b1, `OFS_CTRL, 32'h0000_0008);
        capture_pin <= 1'b1;
        idle(1);
        bus(1'b1, `OFS_GENERAL, {16'h0000, ~rnd[15:0]});
        capture_pin <= 1'b0;
        bus(1'b0, `OFS_GENERAL, {16'h0000, ~rnd[15:0]});
        bus(1'b0, `OFS_FLAGS, 32'h0000_0002);
        idle(2);
        $display("test collisions done");
        summarize();
    end
endmodule : timer_access_contention_arbiter_tb
`default_nettype wire
